/* verilog/ascc_clock_control.v */
// audio system clock control: source select, frequency codes, dividers, enable handshake
`timescale 1ns/1ps
`default_nettype none
`include "ascc_clock_control_regs.vh"
module ascc_clock_control (
	input wire clock,
	input wire rstn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [6:0] source_running,
	input wire domain_idle,
	output reg [2:0] main_clock_source_sel,
	output reg [2:0] main_clock_freq_code,
	output reg main_clock_family_bit,
	output reg main_clock_gate_en,
	output reg domain_stop_req,
	output reg main_clock_off_status,
	output reg off_event,
	output reg gpio_clock_status,
	output reg [2:0] main_proc_rate_code,
	output reg second_clock_gate_en,
	output reg [2:0] second_clock_freq_code,
	output wire [74:0] sample_div
);
	localparam ST_OFF = 2'b00;
	localparam ST_ON = 2'b01;
	localparam ST_STOP = 2'b10;

	reg [31:0] main_cfg_q;
	reg [31:0] sync_rate_q;
	reg [31:0] second_cfg_q;
	reg [31:0] second_rate_q;
	reg [31:0] gpio_route_q;
	reg [1:0] state_q;
	reg [6:0] sync1_q;
	reg [6:0] sync2_q;
	reg [6:0] sync3_q;
	reg [6:0] src_ok_q;
	reg aw_full_q;
	reg w_full_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	wire [31:0] bmask;
	wire do_write;
	wire [4:0] rate_used;
	wire [4:0] rate_valid;
	wire [4:0] rate_family;
	wire [2:0] cfg_freq;
	wire [2:0] cfg_src;
	wire [2:0] cfg_proc;
	wire cfg_family;
	wire cfg_enable;
	wire second_enable;
	wire [2:0] second_freq;
	wire second_family;
	reg main_err;
	reg second_err;
	reg [31:0] rd_d;
	reg [1:0] rresp_d;
	integer k;

	assign cfg_family = main_cfg_q[`ASCC_FAMILY_BIT];
	assign cfg_freq = main_cfg_q[`ASCC_FREQ_LSB+2:`ASCC_FREQ_LSB];
	assign cfg_enable = main_cfg_q[`ASCC_ENABLE_BIT];
	assign cfg_src = main_cfg_q[`ASCC_SRC_LSB+2:`ASCC_SRC_LSB];
	assign cfg_proc = main_cfg_q[`ASCC_PROC_LSB+2:`ASCC_PROC_LSB];
	assign second_enable = second_cfg_q[`ASCC_ENABLE_BIT];
	assign second_freq = second_cfg_q[`ASCC_FREQ_LSB+2:`ASCC_FREQ_LSB];
	// second domain family follows its first rate when that one is in use, otherwise its second rate
	assign second_family = rate_used[3] ? rate_family[3] : rate_family[4];

	// three rate selects on the main clock, two on the second clock
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1)
		begin : gen_rate
			wire [4:0] code;
			if (g < 3)
			begin : gen_main
				assign code = sync_rate_q[g*`ASCC_RATE_STRIDE +: `ASCC_RATE_W];
			end
			else
			begin : gen_second
				assign code = second_rate_q[(g-3)*`ASCC_RATE_STRIDE +: `ASCC_RATE_W];
			end
			ascc_rate_div u_div (
				.clock(clock),
				.rstn(rstn),
				.rate_code(code),
				.freq_code((g < 3) ? cfg_freq : second_freq),
				.second((g < 3) ? 1'b0 : 1'b1),
				.used(rate_used[g]),
				.valid(rate_valid[g]),
				.family(rate_family[g]),
				.div_q(sample_div[g*15 +: 15])
			);
		end
	endgenerate

	// source indications come from pins: three flops, accept once the last two agree
	generate
		for (g = 0; g < 7; g = g + 1)
		begin : gen_sync
			always @(posedge clock or negedge rstn)
			begin
				if (!rstn)
				begin
					sync1_q[g] <= 1'b0;
					sync2_q[g] <= 1'b0;
					sync3_q[g] <= 1'b0;
					src_ok_q[g] <= 1'b0;
				end
				else
				begin
					sync1_q[g] <= source_running[g];
					sync2_q[g] <= sync1_q[g];
					sync3_q[g] <= sync2_q[g];
					if (sync2_q[g] == sync3_q[g])
						src_ok_q[g] <= sync3_q[g];
				end
			end
		end
	endgenerate

	// configuration checks; a bad setting keeps the domain from starting
	always @*
	begin
		main_err = (cfg_freq == `ASCC_FREQ_RESERVED);
		if (cfg_src == `ASCC_SRC_RESERVED)
			main_err = 1'b1;
		second_err = (second_freq > `ASCC_SECOND_FREQ_MAX);
		for (k = 0; k < 5; k = k + 1)
		begin
			if (rate_used[k] && !rate_valid[k])
			begin
				if (k < 3)
					main_err = 1'b1;
				else
					second_err = 1'b1;
			end
			if (k < 3 && rate_used[k] && rate_family[k] != cfg_family)
				main_err = 1'b1;
			if (k >= 3 && rate_used[k] && rate_family[k] != second_family)
				second_err = 1'b1;
		end
	end

	// write path: address and data are taken in either order, then answered together
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
	assign bmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ASCC_RESP_OKAY;
			main_cfg_q <= `ASCC_MAIN_CFG_RST;
			sync_rate_q <= `ASCC_SYNC_RATE_RST;
			second_cfg_q <= `ASCC_SECOND_CFG_RST;
			second_rate_q <= `ASCC_SECOND_RATE_RST;
			gpio_route_q <= `ASCC_GPIO_ROUTE_RST;
		end
		else
		begin
			if (s_axi_awvalid && !aw_full_q)
			begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_q)
			begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_write)
			begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `ASCC_RESP_OKAY;
				// during shutdown nothing is stored, so a premature write shows an error
				if (state_q == ST_STOP)
					s_axi_bresp <= `ASCC_RESP_SLVERR;
				else if (aw_addr_q == `ASCC_OFF_MAIN_CFG)
					main_cfg_q <= ((main_cfg_q & ~bmask) | (w_data_q & bmask))
						& `ASCC_MAIN_CFG_MASK;
				else if (aw_addr_q == `ASCC_OFF_SYNC_RATE)
					sync_rate_q <= ((sync_rate_q & ~bmask) | (w_data_q & bmask))
						& `ASCC_SYNC_RATE_MASK;
				else if (aw_addr_q == `ASCC_OFF_SECOND_CFG)
					second_cfg_q <= ((second_cfg_q & ~bmask) | (w_data_q & bmask))
						& `ASCC_SECOND_CFG_MASK;
				else if (aw_addr_q == `ASCC_OFF_SECOND_RATE)
					second_rate_q <= ((second_rate_q & ~bmask) | (w_data_q & bmask))
						& `ASCC_SECOND_RATE_MASK;
				else if (aw_addr_q == `ASCC_OFF_GPIO_ROUTE)
					gpio_route_q <= ((gpio_route_q & ~bmask) | (w_data_q & bmask))
						& `ASCC_GPIO_ROUTE_MASK;
				else
					s_axi_bresp <= `ASCC_RESP_SLVERR;
			end
		end
	end

	// read path: one outstanding read, data registered
	assign s_axi_arready = !s_axi_rvalid;

	always @*
	begin
		rd_d = 32'h00000000;
		rresp_d = `ASCC_RESP_OKAY;
		if (s_axi_araddr == `ASCC_OFF_MAIN_CFG)
			rd_d = main_cfg_q;
		else if (s_axi_araddr == `ASCC_OFF_SYNC_RATE)
			rd_d = sync_rate_q;
		else if (s_axi_araddr == `ASCC_OFF_SECOND_CFG)
			rd_d = second_cfg_q;
		else if (s_axi_araddr == `ASCC_OFF_SECOND_RATE)
			rd_d = second_rate_q;
		else if (s_axi_araddr == `ASCC_OFF_GPIO_ROUTE)
			rd_d = gpio_route_q;
		else if (s_axi_araddr == `ASCC_OFF_STATUS)
			rd_d = {24'h000000, main_proc_rate_code, state_q == ST_STOP, second_err,
				main_err, main_clock_gate_en, main_clock_off_status};
		else if (s_axi_araddr[7:5] == `ASCC_DIV_BASE_HI && s_axi_araddr[4:2] < 3'h5
			&& s_axi_araddr[1:0] == 2'b00)
			rd_d = {17'h00000, sample_div[s_axi_araddr[4:2]*15 +: 15]};
		else
			rresp_d = `ASCC_RESP_SLVERR;
	end

	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ASCC_RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_d;
			s_axi_rresp <= rresp_d;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// enable handshake; source and frequency outputs are latched at start so live edits cannot glitch them; the main dividers follow the live frequency field
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= ST_OFF;
			main_clock_gate_en <= 1'b0;
			domain_stop_req <= 1'b0;
			main_clock_off_status <= 1'b1;
			main_clock_source_sel <= 3'h0;
			main_clock_freq_code <= 3'h5;
			main_clock_family_bit <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_OFF:
				begin
					// a loop or pin source must already report running
					if (cfg_enable && !main_err && src_ok_q[cfg_src])
					begin
						state_q <= ST_ON;
						main_clock_gate_en <= 1'b1;
						main_clock_off_status <= 1'b0;
						main_clock_source_sel <= cfg_src;
						main_clock_freq_code <= cfg_freq;
						main_clock_family_bit <= cfg_family;
					end
				end
				ST_ON:
				begin
					if (!cfg_enable)
					begin
						state_q <= ST_STOP;
						domain_stop_req <= 1'b1;
					end
				end
				ST_STOP:
				begin
					// clock keeps running until the domain reports idle
					if (domain_idle)
					begin
						state_q <= ST_OFF;
						domain_stop_req <= 1'b0;
						main_clock_gate_en <= 1'b0;
						main_clock_off_status <= 1'b1;
					end
				end
				default:
				begin
					state_q <= ST_OFF;
					domain_stop_req <= 1'b0;
					main_clock_gate_en <= 1'b0;
					main_clock_off_status <= 1'b1;
				end
			endcase
		end
	end

	// event, output pin, processing cap and the simple second domain gate
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			off_event <= 1'b0;
			gpio_clock_status <= 1'b0;
			main_proc_rate_code <= 3'h0;
			second_clock_gate_en <= 1'b0;
			second_clock_freq_code <= 3'h0;
		end
		else
		begin
			off_event <= (state_q == ST_STOP) && domain_idle;
			if (gpio_route_q[0])
				gpio_clock_status <= gpio_route_q[1] ? main_clock_gate_en
					: main_clock_off_status;
			else
				gpio_clock_status <= 1'b0;
			// requested processing rate is capped at the domain clock code of the cycle before, so it can exceed a new code for one cycle
			main_proc_rate_code <= (cfg_proc > main_clock_freq_code) ? main_clock_freq_code
				: cfg_proc;
			second_clock_gate_en <= second_enable && !second_err;
			second_clock_freq_code <= second_freq;
		end
	end
endmodule // ascc_clock_control
`default_nettype wire

/* verilog/ascc_clock_control_regs.vh */
// register offsets, field positions, reset values and codes of the audio clock control
`ifndef ASCC_CLOCK_CONTROL_REGS_VH
`define ASCC_CLOCK_CONTROL_REGS_VH

`define ASCC_OFF_MAIN_CFG 8'h00
`define ASCC_OFF_SYNC_RATE 8'h04
`define ASCC_OFF_SECOND_CFG 8'h08
`define ASCC_OFF_SECOND_RATE 8'h0C
`define ASCC_OFF_STATUS 8'h10
`define ASCC_OFF_GPIO_ROUTE 8'h14
`define ASCC_DIV_BASE_HI 3'h1

`define ASCC_MAIN_CFG_MASK 32'h000F87C7
`define ASCC_SYNC_RATE_MASK 32'h001F1F1F
`define ASCC_SECOND_CFG_MASK 32'h00000740
`define ASCC_SECOND_RATE_MASK 32'h00001F1F
`define ASCC_GPIO_ROUTE_MASK 32'h00000003

`define ASCC_MAIN_CFG_RST 32'h00000500
`define ASCC_SYNC_RATE_RST 32'h00000000
`define ASCC_SECOND_CFG_RST 32'h00000000
`define ASCC_SECOND_RATE_RST 32'h00000000
`define ASCC_GPIO_ROUTE_RST 32'h00000000

`define ASCC_FAMILY_BIT 15
`define ASCC_FREQ_LSB 8
`define ASCC_ENABLE_BIT 6
`define ASCC_PROC_LSB 16
`define ASCC_SRC_LSB 0
`define ASCC_RATE_W 5
`define ASCC_RATE_STRIDE 8

`define ASCC_FREQ_RESERVED 3'h7
`define ASCC_SECOND_FREQ_MAX 3'h3
`define ASCC_SRC_RESERVED 3'h7
`define ASCC_RATE_UNUSED 5'h00

`define ASCC_RESP_OKAY 2'h0
`define ASCC_RESP_SLVERR 2'h2

`endif

/* verilog/ascc_rate_div.v */
// per-rate divider: checks one rate code and derives domain clock cycles per sample
`timescale 1ns/1ps
`default_nettype none
module ascc_rate_div (
	input wire clock,
	input wire rstn,
	input wire [4:0] rate_code,
	input wire [2:0] freq_code,
	input wire second,
	output reg used,
	output reg valid,
	output reg family,
	output reg [14:0] div_q
);
	reg [9:0] base;
	reg [4:0] mult;
	reg [14:0] div_d;

	// cycles per sample at the base clock, in units of 4kHz or 3.675kHz
	always @*
	begin
		used = (rate_code != `ASCC_RATE_UNUSED);
		valid = 1'b1;
		family = 1'b0;
		case (rate_code)
			5'h01: base = 10'h200;
			5'h02: base = 10'h100;
			5'h03: base = 10'h080;
			5'h04: base = 10'h040;
			5'h05: base = 10'h020;
			5'h11: base = 10'h300;
			5'h12: base = 10'h180;
			5'h13: base = 10'h0C0;
			5'h09: begin base = 10'h200; family = 1'b1; end
			5'h0A: begin base = 10'h100; family = 1'b1; end
			5'h0B: begin base = 10'h080; family = 1'b1; end
			5'h0C: begin base = 10'h040; family = 1'b1; end
			5'h0D: begin base = 10'h020; family = 1'b1; end
			default: begin base = 10'h000; valid = 1'b0; end
		endcase
		case (freq_code)
			3'h0: mult = 5'h01;
			3'h1: mult = 5'h02;
			3'h2: mult = 5'h04;
			3'h3: mult = 5'h08;
			3'h4: mult = 5'h0C;
			3'h5: mult = 5'h10;
			3'h6: mult = 5'h18;
			default: mult = 5'h00;
		endcase
		// second domain only knows the four lowest frequency codes
		if (second && freq_code > `ASCC_SECOND_FREQ_MAX)
			mult = 5'h00;
		if (mult == 5'h00)
			valid = 1'b0;
		div_d = valid ? (base * mult) : 15'h0000;
	end

	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			div_q <= 15'h0000;
		else
			div_q <= div_d;
	end
endmodule // ascc_rate_div
`default_nettype wire

/* tb/ascc_clock_control_props.sv */
// assertions on the ports of the audio clock control
`timescale 1ns/1ps
`default_nettype none
module ascc_clock_control_props (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic domain_idle,
	input wire logic [2:0] main_clock_freq_code,
	input wire logic main_clock_gate_en,
	input wire logic domain_stop_req,
	input wire logic main_clock_off_status,
	input wire logic off_event,
	input wire logic [2:0] main_proc_rate_code
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response not held");
	stop_holds_a: assert property (domain_stop_req && !domain_idle |=> domain_stop_req && main_clock_gate_en)
		else $error("shutdown left early");
	idle_ends_stop_a: assert property (domain_stop_req && domain_idle |=> !domain_stop_req && !main_clock_gate_en && main_clock_off_status && off_event)
		else $error("shutdown not finished");
	event_pulse_a: assert property (off_event |=> !off_event)
		else $error("off event too long");
	event_on_off_a: assert property ($rose(main_clock_off_status) |-> off_event)
		else $error("off status without event");
	gate_clears_off_a: assert property ($rose(main_clock_gate_en) |-> $fell(main_clock_off_status))
		else $error("off status kept at start");
	never_both_a: assert property (!(main_clock_gate_en && main_clock_off_status))
		else $error("gate and off status together");
	freq_legal_a: assert property (main_clock_freq_code != 3'h7)
		else $error("reserved frequency code out");
	proc_capped_a: assert property ($stable(main_clock_freq_code) |-> main_proc_rate_code <= main_clock_freq_code)
		else $error("processing rate above clock");
endmodule // ascc_clock_control_props
bind ascc_clock_control ascc_clock_control_props u_ascc_clock_control_props (.clock, .rstn,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .domain_idle,
	.main_clock_freq_code, .main_clock_gate_en, .domain_stop_req, .main_clock_off_status,
	.off_event, .main_proc_rate_code);
`default_nettype wire

/* tb/ascc_far_side.sv */
// model of the clock sources and the main domain functions
`timescale 1ns/1ps
`default_nettype none
module ascc_far_side (
	input wire logic clock,
	input wire logic rstn,
	input wire logic stop_req,
	input wire logic slow,
	input wire logic [6:0] src_on,
	output logic [6:0] source_running,
	output logic domain_idle
);
	logic [3:0] cnt_q;
	// sources are plain levels; a stopped source simply drops its bit
	assign source_running = src_on;
	// functions wind down only after the stop request, slowly when asked
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn || !stop_req)
		begin
			cnt_q <= 4'h0;
			domain_idle <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_q + 4'h1;
			domain_idle <= cnt_q >= (slow ? 4'h8 : 4'h0);
		end
	end
endmodule // ascc_far_side
`default_nettype wire

/* tb/test_audio_system_clock_control.sv */
// self-checking bench for the audio clock control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin errors++; \
	$display("unexpected %s expected %0h seen %0h", nm, e, s); end end
module test_audio_system_clock_control;
	logic clock, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [6:0] source_running, src_on;
	logic domain_idle, slow, main_clock_family_bit, main_clock_gate_en, domain_stop_req;
	logic main_clock_off_status, off_event, gpio_clock_status, second_clock_gate_en;
	logic [2:0] main_clock_source_sel, main_clock_freq_code, main_proc_rate_code;
	logic [2:0] second_clock_freq_code;
	logic [74:0] sample_div;
	int errors, total_checks, cyc;
	ascc_clock_control u_ascc_clock_control (.clock, .rstn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .source_running,
		.domain_idle, .main_clock_source_sel, .main_clock_freq_code, .main_clock_family_bit,
		.main_clock_gate_en, .domain_stop_req, .main_clock_off_status, .off_event,
		.gpio_clock_status, .main_proc_rate_code, .second_clock_gate_en,
		.second_clock_freq_code, .sample_div);
	ascc_far_side u_ascc_far_side (.clock, .rstn, .stop_req(domain_stop_req), .slow, .src_on,
		.source_running, .domain_idle);
	task close_out;
	begin
		$display("errors %0d total_checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
	begin
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	end
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
	begin
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	end
	endtask
	task t_reset;
	begin
		rd(8'h00, rd_d, rs);
		`CHK("main cfg", 32'h00000500, rd_d)
		rd(8'h10, rd_d, rs);
		`CHK("status", 32'h00000001, rd_d)
		`CHK("freq out", 3'h5, main_clock_freq_code)
		`CHK("family out", 1'b0, main_clock_family_bit)
	end
	endtask
	task t_err;
	begin
		src_on <= 7'h01;
		wr(8'h04, 32'h0000000B, rs);
		wr(8'h00, 32'h00000540, rs);
		repeat (10) @(posedge clock);
		`CHK("gate family", 1'b0, main_clock_gate_en)
		rd(8'h10, rd_d, rs);
		`CHK("family err", 1'b1, rd_d[2])
		wr(8'h00, 32'h00000740, rs);
		wr(8'h04, 32'h00000000, rs);
		repeat (10) @(posedge clock);
		`CHK("gate reserved", 1'b0, main_clock_gate_en)
		rd(8'h10, rd_d, rs);
		`CHK("reserved err", 1'b1, rd_d[2])
		wr(8'h00, 32'h00000500, rs);
	end
	endtask
	task t_enable;
	begin
		wr(8'h04, 32'h00110503, rs);
		// freq code 101 names the 98.304MHz that the modelled source gives
		wr(8'h00, 32'h00070542, rs);
		repeat (10) @(posedge clock);
		`CHK("gate no source", 1'b0, main_clock_gate_en)
		src_on <= 7'h05;
		repeat (20) if (main_clock_gate_en !== 1'b1) @(posedge clock);
		`CHK("gate on", 1'b1, main_clock_gate_en)
		`CHK("off cleared", 1'b0, main_clock_off_status)
		`CHK("source", 3'h2, main_clock_source_sel)
		`CHK("proc rate", 3'h5, main_proc_rate_code)
		repeat (3) @(posedge clock);
		`CHK("dividers", {15'h3000, 15'h0200, 15'h0800}, sample_div[44:0])
		rd(8'h20, rd_d, rs);
		`CHK("divider reg", 32'h00000800, rd_d)
		rd(8'h10, rd_d, rs);
		`CHK("status on", 32'h000000A2, rd_d)
	end
	endtask
	task t_disable;
	begin
		wr(8'h14, 32'h00000001, rs);
		repeat (3) @(posedge clock);
		`CHK("gpio running", 1'b0, gpio_clock_status)
		slow <= 1'b1;
		wr(8'h00, 32'h00070502, rs);
		`CHK("clear resp", 2'h0, rs)
		wr(8'h14, 32'h00000003, rs);
		`CHK("busy write", 2'h2, rs)
		repeat (30) if (main_clock_off_status !== 1'b1) @(posedge clock);
		`CHK("off set", 1'b1, main_clock_off_status)
		`CHK("off event", 1'b1, off_event)
		`CHK("gate off", 1'b0, main_clock_gate_en)
		repeat (2) @(posedge clock);
		`CHK("event gone", 1'b0, off_event)
		`CHK("gpio stopped", 1'b1, gpio_clock_status)
		wr(8'h14, 32'h00000003, rs);
		`CHK("write after", 2'h0, rs)
		repeat (3) @(posedge clock);
		`CHK("gpio gate", 1'b0, gpio_clock_status)
	end
	endtask
	task t_second;
	begin
		wr(8'h0C, 32'h00000D0B, rs);
		wr(8'h08, 32'h00000440, rs);
		repeat (5) @(posedge clock);
		`CHK("second bad freq", 1'b0, second_clock_gate_en)
		rd(8'h10, rd_d, rs);
		`CHK("second err", 1'b1, rd_d[3])
		wr(8'h08, 32'h00000340, rs);
		repeat (5) @(posedge clock);
		`CHK("second on", 1'b1, second_clock_gate_en)
		`CHK("second freq", 3'h3, second_clock_freq_code)
		`CHK("second div", {15'h0100, 15'h0400}, sample_div[74:45])
		wr(8'h0C, 32'h00000D03, rs);
		repeat (5) @(posedge clock);
		`CHK("mixed family", 1'b0, second_clock_gate_en)
	end
	endtask
	task t_bus;
	begin
		rd(8'h40, rd_d, rs);
		`CHK("unmapped resp", 2'h2, rs)
		`CHK("unmapped data", 32'h00000000, rd_d)
		wr(8'h10, 32'h00000000, rs);
		`CHK("status write", 2'h2, rs)
		rd(8'h08, rd_d, rs);
		`CHK("second cfg", 32'h00000340, rd_d)
		rd(8'h34, rd_d, rs);
		`CHK("no port divider", 2'h2, rs)
		wr(8'h08, 32'h00000000, rs);
		repeat (5) @(posedge clock);
		`CHK("second parked", 1'b0, second_clock_gate_en)
	end
	endtask
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			close_out;
		end
	end
	initial
	begin
		rstn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		src_on = 7'h00;
		slow = 1'b0;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		t_reset;
		t_err;
		t_enable;
		t_disable;
		t_second;
		t_bus;
		close_out;
	end
endmodule // test_audio_system_clock_control
`default_nettype wire
